// ---- dv/pmr_chk_sva.sv ----
// Port checks for the power-management event routing and timer block.
`timescale 1ns/100ps
module pmr_chk (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr_strobe,
    input wire logic        rd_strobe,
    input wire logic [7:0]  rdata,
    input wire logic        smi_n,
    input wire logic        sci_n,
    input wire logic [15:0] irq_out,
    input wire logic        serial_irq_line_in,
    input wire logic        serial_irq_line_out,
    input wire logic        serial_irq_line_oe_n
);
    logic sirq_q;
    // Tracks the serial interrupt mode bit as written by software.
    always_ff @(posedge clock)
    begin
        if (rst)
            sirq_q <= 1'b0;
        else if (wr_strobe && addr == pmr_pkg::OFS_CFG)
            sirq_q <= wdata[pmr_pkg::B_SIRQ];
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);
    sequence rls_wr_s;
        wr_strobe && addr == pmr_pkg::OFS_CTRL && wdata[pmr_pkg::B_FW_RLS];
    endsequence
    sequence os_wr_s;
        wr_strobe && addr == pmr_pkg::OFS_CFG && wdata[pmr_pkg::B_OS_RLS];
    endsequence
    sequence bm_wr_s;
        wr_strobe && addr == pmr_pkg::OFS_CFG && wdata[pmr_pkg::B_BM_CTL];
    endsequence
    sequence sts_rd_s;
        rd_strobe && addr == pmr_pkg::OFS_STS1;
    endsequence
    sequence cfg_rd_s;
        rd_strobe && addr == pmr_pkg::OFS_CFG;
    endsequence
    gbl_set_a: assert property (rls_wr_s ##1 sts_rd_s |=> rdata[pmr_pkg::B_GLOBAL_EVENT_STATUS])
        else $error("global status not set by release");
    os_set_a: assert property (os_wr_s ##1 cfg_rd_s |=>
        rdata[pmr_pkg::B_OS_RLS] && rdata[pmr_pkg::B_FW_STS]) else $error("os release failed");
    bm_set_a: assert property (bm_wr_s ##1 sts_rd_s |=> rdata[pmr_pkg::B_BUSMASTER_STATUS])
        else $error("busmaster status not set");
    rd_idle_a: assert property (!$past(rd_strobe) |-> rdata == 8'h00)
        else $error("read data outside read cycle");
    unmapped_rd_a: assert property (rd_strobe && addr == 8'h20 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    sts_resv_a: assert property (sts_rd_s |=> rdata[3:1] == 3'h0 && rdata[7:6] == 2'h0)
        else $error("reserved status bits set");
    irq_hot_a: assert property ($onehot0(irq_out))
        else $error("more than one irq line");
    sci_one_a: assert property (!sci_n |-> irq_out == 16'h0000)
        else $error("sci on pin and irq line");
    sirq_out_a: assert property (serial_irq_line_out == 1'b0)
        else $error("serial line data not low");
    sirq_pulse_a: assert property ($fell(serial_irq_line_oe_n) |=> serial_irq_line_oe_n)
        else $error("serial pull longer than one cycle");
    serial_idle_a: assert property (sirq_q && $past(sirq_q) |=>
        smi_n && sci_n && irq_out == 16'h0000) else $error("pins active in serial mode");
    smi_os_a: assert property (wr_strobe && addr == pmr_pkg::OFS_CFG &&
        wdata[pmr_pkg::B_FW_EN] && wdata[pmr_pkg::B_OS_RLS] && !wdata[pmr_pkg::B_SIRQ]
        |-> ##[1:3] !smi_n) else $error("smi not raised by os release");
endmodule : pmr_chk
bind pmr_top pmr_chk u_chk (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .smi_n(smi_n),
    .sci_n(sci_n), .irq_out(irq_out), .serial_irq_line_in(serial_irq_line_in),
    .serial_irq_line_out(serial_irq_line_out), .serial_irq_line_oe_n(serial_irq_line_oe_n));

// ---- dv/pmr_host_model.sv ----
// Host side of the serial interrupt line: start pulse and slot sampling.
`timescale 1ns/100ps
module pmr_host_model (
    input  wire logic       clock,
    input  wire logic       go,
    input  wire logic [3:0] start_len,
    input  wire logic       dev_out,
    input  wire logic       dev_oe_n,
    output logic            line,
    output logic            done,
    output int              npulse,
    output int              pos0,
    output int              pos1
);
    logic host_low;
    int   cnt;
    // The line has a pull-up, so it reads high when nobody pulls it.
    assign line = host_low ? 1'b0 : (dev_oe_n ? 1'b1 : dev_out);
    initial
    begin
        host_low = 1'b0;
        done     = 1'b0;
        npulse   = 0;
        pos0     = 0;
        pos1     = 0;
    end
    // Drives the start pulse, then records where the device pulls the line.
    always @(posedge clock)
    begin
        if (go)
        begin
            done     <= 1'b0;
            npulse   = 0;
            host_low <= 1'b1;
            repeat (start_len) @(posedge clock);
            host_low <= 1'b0;
            for (cnt = 0; cnt < 120; cnt++)
            begin
                @(posedge clock);
                if (line === 1'b0)
                begin
                    if (npulse == 0)
                        pos0 = cnt;
                    else
                        pos1 = cnt;
                    npulse++;
                end
            end
            done <= 1'b1;
        end
    end
endmodule : pmr_host_model

// ---- dv/tb_top.sv ----
// Self-checking testbench for the event routing and timer block.
`timescale 1ns/100ps
module tb_top;
    logic        clock, rst, wr_strobe, rd_strobe, smi_n, sci_n;
    logic [7:0]  addr, wdata, rdata, v, t0;
    logic [15:0] irq_out;
    logic        line, line_out, line_oe_n, go, done;
    logic [3:0]  start_len;
    int          npulse, pos0, pos1, fails, checked;
    initial clock = 1'b0;
    always #4 clock = ~clock;
    pmr_top dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rdata(rdata), .smi_n(smi_n), .sci_n(sci_n), .irq_out(irq_out),
        .serial_irq_line_in(line), .serial_irq_line_out(line_out),
        .serial_irq_line_oe_n(line_oe_n));
    pmr_host_model host (.clock(clock), .go(go), .start_len(start_len), .dev_out(line_out),
        .dev_oe_n(line_oe_n), .line(line), .done(done), .npulse(npulse), .pos0(pos0),
        .pos1(pos1));
    task automatic close_out;
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: %s got %h", $time, msg, got);
            fails++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_strobe <= 1'b1;
        addr      <= a;
        wdata     <= d;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        rd_strobe <= 1'b1;
        addr      <= a;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] ra,
                         output logic [7:0] q);
        wr(a, d);
        rd_strobe <= 1'b1;
        addr      <= ra;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1 q = rdata;
    endtask : wr_rd
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        rd(a, q);
        chk(q, e, "register read");
    endtask : rchk
    task automatic pins(input logic s, input logic c, input logic [15:0] i);
        repeat (3) @(posedge clock);
        #1 chk({smi_n, sci_n, irq_out}, {6'h0, s, c, i}, "interrupt pins");
    endtask : pins
    task automatic frame(input logic [3:0] len, input int n, input int gap);
        int i;
        @(posedge clock);
        start_len <= len;
        go        <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        // Let the model drop the done flag of the previous frame first.
        @(posedge clock);
        for (i = 0; i < 300 && done !== 1'b1; i++)
            @(posedge clock);
        if (done !== 1'b1)
        begin
            fails++;
            close_out();
        end
        else
        begin
            chk(24'(npulse), 24'(n), "serial pulse count");
            if (n == 2)
                chk(24'(pos1 - pos0), 24'(gap), "serial slot spacing");
        end
    endtask : frame
    initial
    begin
        {rst, wr_strobe, rd_strobe, go} = 4'hf;
        {wr_strobe, rd_strobe, go} = 3'h0;
        {addr, wdata, start_len} = 20'h00004;
        fails   = 0;
        checked = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rchk(8'h00, 8'h00);
        rchk(8'h10, 8'h00);
        pins(1'b1, 1'b1, 16'h0000);
        wr(8'h02, 8'hff);
        rchk(8'h02, 8'h21);
        wr(8'h0c, 8'hfe);
        rchk(8'h0c, 8'h00);
        wr(8'h11, 8'hff);
        rchk(8'h11, 8'h0f);
        wr(8'h20, 8'hff);
        rchk(8'h20, 8'h00);
        wr(8'h02, 8'h00);
        rd(8'h08, t0);
        repeat (100) @(posedge clock);
        rchk(8'h08, t0);
        wr_rd(8'h04, 8'h04, 8'h00, v);
        chk(v, 8'h20, "global status after release");
        wr(8'h02, 8'h20);
        wr(8'h04, 8'h01);
        rchk(8'h04, 8'h05);
        pins(1'b1, 1'b0, 16'h0000);
        wr(8'h00, 8'h00);
        pins(1'b1, 1'b0, 16'h0000);
        wr(8'h10, 8'h40);
        for (int s = 0; s < 16; s++)
        begin
            wr(8'h11, 8'(s));
            pins(1'b1, 1'b1, 16'h0001 << s);
        end
        wr(8'h10, 8'h00);
        wr(8'h00, 8'h20);
        rchk(8'h04, 8'h01);
        rchk(8'h00, 8'h00);
        pins(1'b1, 1'b1, 16'h0000);
        wr_rd(8'h10, 8'h10, 8'h00, v);
        chk(v, 8'h10, "busmaster status");
        wr(8'h04, 8'h03);
        pins(1'b1, 1'b0, 16'h0000);
        wr(8'h10, 8'h00);
        rchk(8'h10, 8'h10);
        wr(8'h00, 8'h10);
        rchk(8'h10, 8'h00);
        pins(1'b1, 1'b1, 16'h0000);
        wr_rd(8'h10, 8'h08, 8'h10, v);
        chk(v, 8'h0c, "os release");
        pins(1'b1, 1'b1, 16'h0000);
        wr(8'h10, 8'h0a);
        pins(1'b0, 1'b1, 16'h0000);
        wr(8'h10, 8'h06);
        rchk(8'h10, 8'h02);
        pins(1'b1, 1'b1, 16'h0000);
        wr(8'h10, 8'h01);
        wr(8'h04, 8'h04);
        pins(1'b0, 1'b1, 16'h0000);
        wr(8'h00, 8'h20);
        pins(1'b1, 1'b1, 16'h0000);
        wr(8'h10, 8'h21);
        wr(8'h11, 8'h05);
        wr(8'h04, 8'h05);
        pins(1'b1, 1'b1, 16'h0000);
        frame(4'h4, 2, 9);
        frame(4'h3, 0, 0);
        wr(8'h10, 8'h00);
        wr(8'h00, 8'h20);
        wr(8'h0c, 8'h01);
        rd(8'h08, t0);
        repeat (700) @(posedge clock);
        rd(8'h08, v);
        v = v - t0;
        chk(24'(v >= 8'h13 && v <= 8'h15), 24'h1, "timer rate");
        rchk(8'h0a, 8'h00);
        close_out();
    end
endmodule : tb_top

// ---- inc/pmr_pkg.sv ----
// Shared constants for the power-management event routing and timer block.
package pmr_pkg;

    // Register port widths.
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 8;

    // Register byte addresses.
    localparam logic [7:0] OFS_STS1  = 8'h00;
    localparam logic [7:0] OFS_EN1   = 8'h02;
    localparam logic [7:0] OFS_CTRL  = 8'h04;
    localparam logic [7:0] OFS_TMR0  = 8'h08;
    localparam logic [7:0] OFS_TMR1  = 8'h09;
    localparam logic [7:0] OFS_TMR2  = 8'h0a;
    localparam logic [7:0] OFS_GPE   = 8'h0c;
    localparam logic [7:0] OFS_CFG   = 8'h10;
    localparam logic [7:0] OFS_SEL   = 8'h11;

    // Status register 1 fields.
    localparam int unsigned B_PM_TIMER_CARRY_STATUS = 0;
    localparam int unsigned B_BUSMASTER_STATUS  = 4;
    localparam int unsigned B_GLOBAL_EVENT_STATUS = 5;

    // Enable register 1 fields.
    localparam int unsigned B_PM_TIMER_IRQ_ENABLE  = 0;
    localparam int unsigned B_GLOBAL_EVENT_ENABLE  = 5;

    // Control register fields.
    localparam int unsigned B_ACPI_EN = 0;
    localparam int unsigned B_BUSMASTER_RELOAD_ENABLE  = 1;
    localparam int unsigned B_FW_RLS  = 2;

    // General-purpose event register field.
    localparam int unsigned B_TMR_RUN = 0;

    // Configuration register fields.
    localparam int unsigned B_LEG_EN  = 0;
    localparam int unsigned B_FW_EN   = 1;
    localparam int unsigned B_FW_STS  = 2;
    localparam int unsigned B_OS_RLS  = 3;
    localparam int unsigned B_BM_CTL  = 4;
    localparam int unsigned B_SIRQ    = 5;
    localparam int unsigned B_SCI_IRQ = 6;

    // Timer and routing sizes.
    localparam int unsigned TMR_W = 24;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned IRQ_N = 16;

    // Clock rates in hertz.
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned TMR_HZ = 3579545;

    // Serial interrupt frame timing in clock cycles.
    localparam int unsigned SIRQ_START_MIN = 4;
    localparam int unsigned SIRQ_SLOT_CYC  = 3;
    localparam int unsigned SIRQ_SLOTS     = 32;
    localparam int unsigned SIRQ_SMI_SLOT  = 2;

endpackage : pmr_pkg

// ---- rtl/pmr_sirq.sv ----
// Serial interrupt line slot driver for the routed interrupts.
`timescale 1ns/100ps
module pmr_sirq (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     smi_req,
    input  wire logic                     sci_req,
    input  wire logic [pmr_pkg::SEL_W-1:0] sci_slot,
    input  wire logic                     line_in,
    output logic                          line_out,
    output logic                          line_oe_n
);

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_SLOTS} pmr_sirq_e;

    typedef struct packed {
        pmr_sirq_e  st;
        logic       s1;
        logic       s2;
        logic [3:0] cnt;
        logic [4:0] slot;
        logic [1:0] phase;
        logic       oe_n;
    } pmr_sirq_s;

    pmr_sirq_s s_q;
    pmr_sirq_s s_d;
    logic      hit;

    always_comb
    begin
        s_d      = s_q;
        s_d.s1   = line_in;
        s_d.s2   = s_q.s1;
        s_d.oe_n = 1'b1;
        hit      = (smi_req && s_q.slot == 5'(pmr_pkg::SIRQ_SMI_SLOT))
                || (sci_req && s_q.slot == 5'(sci_slot));
        case (s_q.st)
            ST_IDLE:
            begin
                s_d.cnt = '0;
                if (!s_q.s2)
                    s_d.st = ST_START;
            end
            ST_START:
            begin
                if (!s_q.s2)
                begin
                    if (s_q.cnt != 4'hf)
                        s_d.cnt = s_q.cnt + 4'h1;
                end
                else if (s_q.cnt >= 4'(pmr_pkg::SIRQ_START_MIN - 1))
                begin
                    s_d.st    = ST_SLOTS;
                    s_d.slot  = '0;
                    s_d.phase = '0;
                end
                else
                begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_SLOTS:
            begin
                if (s_q.phase == 2'(pmr_pkg::SIRQ_SLOT_CYC - 1))
                begin
                    s_d.phase = '0;
                    s_d.slot  = s_q.slot + 5'h1;
                    if (s_q.slot == 5'(pmr_pkg::SIRQ_SLOTS - 1))
                        s_d.st = ST_IDLE;
                end
                else
                begin
                    s_d.phase = s_q.phase + 2'h1;
                end
                if (s_q.phase == 2'h0 && hit)
                    s_d.oe_n = 1'b0;
            end
            default:
            begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_q      <= '0;
            s_q.s1   <= 1'b1;
            s_q.s2   <= 1'b1;
            s_q.oe_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign line_out  = 1'b0;
    assign line_oe_n = s_q.oe_n;

endmodule : pmr_sirq

// ---- rtl/pmr_tick.sv ----
// Fractional divider giving a one-cycle enable at the timer rate.
`timescale 1ns/100ps
module pmr_tick #(
    parameter int unsigned CLK_HZ = pmr_pkg::CLK_HZ,
    parameter int unsigned TMR_HZ = pmr_pkg::TMR_HZ
) (
    input  wire logic clock,
    input  wire logic rst,
    output logic      tick
);

    localparam logic [27:0] MODV = 28'(CLK_HZ);
    localparam logic [27:0] INCV = 28'(TMR_HZ);

    typedef struct packed {
        logic [27:0] acc;
        logic        tick;
    } pmr_tick_s;

    pmr_tick_s s_q;
    pmr_tick_s s_d;
    logic [27:0] sum;

    always_comb
    begin
        s_d      = s_q;
        sum      = s_q.acc + INCV;
        s_d.tick = 1'b0;
        if (sum >= MODV)
        begin
            s_d.acc  = sum - MODV;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.acc = sum;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign tick = s_q.tick;

endmodule : pmr_tick

// ---- rtl/pmr_top.sv ----
// Power-management event routing, release handshakes and a timer that counts while its run bit is set.
`timescale 1ns/100ps

module pmr_top (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic [pmr_pkg::AW-1:0]     addr,
    input  wire logic [pmr_pkg::DW-1:0]     wdata,
    input  wire logic                       wr_strobe,
    input  wire logic                       rd_strobe,
    output logic      [pmr_pkg::DW-1:0]     rdata,
    output logic                            smi_n,
    output logic                            sci_n,
    output logic      [pmr_pkg::IRQ_N-1:0]  irq_out,
    input  wire logic                       serial_irq_line_in,
    output logic                            serial_irq_line_out,
    output logic                            serial_irq_line_oe_n
);

    typedef struct packed {
        logic [pmr_pkg::TMR_W-1:0] tmr_cnt;
        logic                      pm_timer_carry_status;
        logic                      pm_timer_irq_enable;
        logic                      tmr_run;
        logic                      busmaster_status;
        logic                      bm_ctl;
        logic                      busmaster_reload_enable;
        logic                      global_event_status;
        logic                      global_event_enable;
        logic                      fw_rls;
        logic                      os_rls;
        logic                      fw_sts;
        logic                      fw_en;
        logic                      acpi_en;
        logic                      legacy_en;
        logic                      sirq_mode;
        logic                      sci_on_irq;
        logic [pmr_pkg::SEL_W-1:0] sci_sel;
        logic [pmr_pkg::DW-1:0]    rdata;
        logic                      smi_n;
        logic                      sci_n;
        logic [pmr_pkg::IRQ_N-1:0] irq_out;
    } pmr_state_s;

    pmr_state_s s_q;
    pmr_state_s s_d;

    logic tick;
    logic wr_sts1;
    logic wr_en1;
    logic wr_ctrl;
    logic wr_gpe;
    logic wr_cfg;
    logic wr_sel;
    logic pm_evt;
    logic smi_act;
    logic sci_act;
    logic carry;

    // One-cycle enable at the timer rate, derived from the host clock.
    pmr_tick u_tick (
        .clock (clock),
        .rst   (rst),
        .tick  (tick)
    );

    // Serial interrupt slot driver.
    pmr_sirq u_sirq (
        .clock     (clock),
        .rst       (rst),
        .smi_req   (smi_act && s_q.sirq_mode),
        .sci_req   (sci_act && s_q.sirq_mode),
        .sci_slot  (s_q.sci_sel),
        .line_in   (serial_irq_line_in),
        .line_out  (serial_irq_line_out),
        .line_oe_n (serial_irq_line_oe_n)
    );

    // Write decode.
    always_comb
    begin
        wr_sts1 = wr_strobe && addr == pmr_pkg::OFS_STS1;
        wr_en1  = wr_strobe && addr == pmr_pkg::OFS_EN1;
        wr_ctrl = wr_strobe && addr == pmr_pkg::OFS_CTRL;
        wr_gpe  = wr_strobe && addr == pmr_pkg::OFS_GPE;
        wr_cfg  = wr_strobe && addr == pmr_pkg::OFS_CFG;
        wr_sel  = wr_strobe && addr == pmr_pkg::OFS_SEL;
    end

    // Enabled event sources and their routing.
    always_comb
    begin
        pm_evt = (s_q.pm_timer_carry_status && s_q.pm_timer_irq_enable)
              || (s_q.fw_rls && s_q.global_event_enable)
              || (s_q.bm_ctl && s_q.busmaster_reload_enable);
        sci_act = s_q.acpi_en && pm_evt;
        smi_act = (s_q.legacy_en && pm_evt)
               || (s_q.os_rls && s_q.fw_en);
    end

    // Timer carry out of the lower bits flips the top bit.
    always_comb
    begin
        carry = s_q.tmr_run && tick
             && (&s_q.tmr_cnt[pmr_pkg::TMR_W-2:0]);
    end

    always_comb
    begin
        s_d = s_q;

        // Timer counts only while run is set.
        if (s_q.tmr_run && tick)
        begin
            s_d.tmr_cnt = s_q.tmr_cnt + 24'h1;
        end

        // Status register: write one clears, zero leaves alone.
        if (wr_sts1)
        begin
            if (wdata[pmr_pkg::B_PM_TIMER_CARRY_STATUS])
            begin
                s_d.pm_timer_carry_status = 1'b0;
            end
            if (wdata[pmr_pkg::B_BUSMASTER_STATUS])
            begin
                s_d.busmaster_status = 1'b0;
                s_d.bm_ctl = 1'b0;
            end
            if (wdata[pmr_pkg::B_GLOBAL_EVENT_STATUS])
            begin
                s_d.global_event_status = 1'b0;
                s_d.fw_rls  = 1'b0;
            end
        end

        // Enable register.
        if (wr_en1)
        begin
            s_d.pm_timer_irq_enable = wdata[pmr_pkg::B_PM_TIMER_IRQ_ENABLE];
            s_d.global_event_enable = wdata[pmr_pkg::B_GLOBAL_EVENT_ENABLE];
        end

        // Control register; release bit is set-only.
        if (wr_ctrl)
        begin
            s_d.acpi_en = wdata[pmr_pkg::B_ACPI_EN];
            s_d.busmaster_reload_enable  = wdata[pmr_pkg::B_BUSMASTER_RELOAD_ENABLE];
            if (wdata[pmr_pkg::B_FW_RLS])
            begin
                s_d.fw_rls  = 1'b1;
                s_d.global_event_status = 1'b1;
            end
        end

        // General-purpose event register.
        if (wr_gpe)
        begin
            s_d.tmr_run = wdata[pmr_pkg::B_TMR_RUN];
        end

        // Configuration: clears are applied before sets so a set wins.
        if (wr_cfg)
        begin
            s_d.legacy_en  = wdata[pmr_pkg::B_LEG_EN];
            s_d.fw_en      = wdata[pmr_pkg::B_FW_EN];
            s_d.sirq_mode  = wdata[pmr_pkg::B_SIRQ];
            s_d.sci_on_irq = wdata[pmr_pkg::B_SCI_IRQ];
            if (wdata[pmr_pkg::B_FW_STS])
            begin
                s_d.fw_sts = 1'b0;
                s_d.os_rls = 1'b0;
            end
            if (wdata[pmr_pkg::B_OS_RLS])
            begin
                s_d.os_rls = 1'b1;
                s_d.fw_sts = 1'b1;
            end
            if (wdata[pmr_pkg::B_BM_CTL])
            begin
                s_d.bm_ctl = 1'b1;
                s_d.busmaster_status = 1'b1;
            end
        end

        // Interrupt select field.
        if (wr_sel)
        begin
            s_d.sci_sel = wdata[pmr_pkg::SEL_W-1:0];
        end

        // Hardware set beats a simultaneous software clear.
        if (carry)
        begin
            s_d.pm_timer_carry_status = 1'b1;
        end

        // Read data stand only in the cycle after the read strobe.
        s_d.rdata = '0;
        if (rd_strobe)
        begin
            case (addr)
                pmr_pkg::OFS_STS1:
                begin
                    s_d.rdata[pmr_pkg::B_PM_TIMER_CARRY_STATUS] = s_q.pm_timer_carry_status;
                    s_d.rdata[pmr_pkg::B_BUSMASTER_STATUS]  = s_q.busmaster_status;
                    s_d.rdata[pmr_pkg::B_GLOBAL_EVENT_STATUS] = s_q.global_event_status;
                end
                pmr_pkg::OFS_EN1:
                begin
                    s_d.rdata[pmr_pkg::B_PM_TIMER_IRQ_ENABLE] = s_q.pm_timer_irq_enable;
                    s_d.rdata[pmr_pkg::B_GLOBAL_EVENT_ENABLE] = s_q.global_event_enable;
                end
                pmr_pkg::OFS_CTRL:
                begin
                    s_d.rdata[pmr_pkg::B_ACPI_EN] = s_q.acpi_en;
                    s_d.rdata[pmr_pkg::B_BUSMASTER_RELOAD_ENABLE]  = s_q.busmaster_reload_enable;
                    s_d.rdata[pmr_pkg::B_FW_RLS]  = s_q.fw_rls;
                end
                pmr_pkg::OFS_TMR0:
                begin
                    s_d.rdata = s_q.tmr_cnt[7:0];
                end
                pmr_pkg::OFS_TMR1:
                begin
                    s_d.rdata = s_q.tmr_cnt[15:8];
                end
                pmr_pkg::OFS_TMR2:
                begin
                    s_d.rdata = s_q.tmr_cnt[23:16];
                end
                pmr_pkg::OFS_GPE:
                begin
                    s_d.rdata[pmr_pkg::B_TMR_RUN] = s_q.tmr_run;
                end
                pmr_pkg::OFS_CFG:
                begin
                    s_d.rdata[pmr_pkg::B_LEG_EN]  = s_q.legacy_en;
                    s_d.rdata[pmr_pkg::B_FW_EN]   = s_q.fw_en;
                    s_d.rdata[pmr_pkg::B_FW_STS]  = s_q.fw_sts;
                    s_d.rdata[pmr_pkg::B_OS_RLS]  = s_q.os_rls;
                    s_d.rdata[pmr_pkg::B_BM_CTL]  = s_q.bm_ctl;
                    s_d.rdata[pmr_pkg::B_SIRQ]    = s_q.sirq_mode;
                    s_d.rdata[pmr_pkg::B_SCI_IRQ] = s_q.sci_on_irq;
                end
                pmr_pkg::OFS_SEL:
                begin
                    s_d.rdata[pmr_pkg::SEL_W-1:0] = s_q.sci_sel;
                end
                default:
                begin
                    s_d.rdata = '0;
                end
            endcase
        end

        // Dedicated pins are used only outside serial mode.
        s_d.smi_n   = !(smi_act && !s_q.sirq_mode);
        s_d.sci_n   = !(sci_act && !s_q.sirq_mode && !s_q.sci_on_irq);
        s_d.irq_out = '0;
        if (sci_act && !s_q.sirq_mode && s_q.sci_on_irq)
        begin
            s_d.irq_out[s_q.sci_sel] = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_q       <= '0;
            s_q.smi_n <= 1'b1;
            s_q.sci_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata   = s_q.rdata;
    assign smi_n   = s_q.smi_n;
    assign sci_n   = s_q.sci_n;
    assign irq_out = s_q.irq_out;

endmodule : pmr_top
